/* File: dsf_status_flags.sv */
// module: dma status event flags, engine suspend control, avalon slave
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module dsf_status_flags
    import dsf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    input wire dsf_events_t ev,
    output logic irq,
    output logic txSuspend,
    output logic txHalt,
    output logic rxSuspend,
    output logic [31:0] txDescStatusWord,
    output logic txDescStatusWrite
);
    //======================================================================
    // helpers
    function automatic logic [31:0] beMask(input logic [3:0] be);
        beMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        merge = (old & ~beMask(be)) | (wd & beMask(be));
    endfunction

    dsf_state_t st;
    dsf_state_t next_st;
    logic access;
    logic accept;
    logic [31:0] wdMasked;
    logic [31:0] setBits;
    logic [31:0] clrBits;
    logic [31:0] statusView;
    logic gpExpire;
    logic wdExpire;
    logic txPoll;
    logic rxPoll;

    //======================================================================
    // next state
    always_comb
    begin
        next_st = st;
        access = avsRead | avsWrite;
        accept = access & ~st.waitReq;
        wdMasked = avsWritedata & beMask(avsByteenable);
        setBits = RESET_ZERO;
        clrBits = RESET_ZERO;
        gpExpire = 1'b0;
        wdExpire = 1'b0;
        txPoll = 1'b0;
        rxPoll = 1'b0;
        statusView = st.flags;
        statusView[BIT_NORMAL_SUM] = |(st.flags & NORMAL_MASK);
        statusView[BIT_ABNORMAL_SUM] = |(st.flags & ABNORMAL_MASK);

        // bus: one wait cycle, then the access completes
        next_st.waitReq = ~(access & st.waitReq);
        if (access && st.waitReq)
        begin
            case (avsAddress)
                ADDR_STATUS: next_st.readData = statusView;
                ADDR_MASK: next_st.readData = st.mask;
                ADDR_GP_TIMER: next_st.readData = {15'h0000, st.gpCfg};
                ADDR_WATCHDOG: next_st.readData = {15'h0000, st.wdCfg};
                ADDR_POLL:
                begin
                    next_st.readData = RESET_ZERO;
                    next_st.readData[POLL_AUTO_BIT] = st.autoPoll;
                    next_st.readData[POLL_TX_SUSP_BIT] = st.txState[0];
                    next_st.readData[POLL_RX_SUSP_BIT] = st.rxState[0];
                end
                default: next_st.readData = RESET_ZERO;
            endcase
        end

        if (accept && avsWrite)
        begin
            case (avsAddress)
                ADDR_STATUS: clrBits = wdMasked & FLAG_MASK;
                ADDR_MASK: next_st.mask =
                    merge(st.mask, avsWritedata, avsByteenable) & FLAG_MASK;
                ADDR_GP_TIMER:
                begin
                    next_st.gpCfg = 17'(merge({15'h0000, st.gpCfg},
                        avsWritedata, avsByteenable));
                    next_st.gpCount = next_st.gpCfg[15:0];
                end
                ADDR_WATCHDOG:
                begin
                    next_st.wdCfg = 17'(merge({15'h0000, st.wdCfg},
                        avsWritedata, avsByteenable));
                    next_st.wdCount = 16'h0000;
                end
                ADDR_POLL:
                begin
                    txPoll = wdMasked[POLL_TX_BIT];
                    rxPoll = wdMasked[POLL_RX_BIT];
                    if (avsByteenable[0])
                        next_st.autoPoll = avsWritedata[POLL_AUTO_BIT];
                end
                default: next_st.autoPoll = st.autoPoll;
            endcase
        end

        if (st.gpCount != 16'h0000 && !(accept && avsWrite &&
            avsAddress == ADDR_GP_TIMER))
        begin
            next_st.gpCount = st.gpCount - 16'h0001;
            if (st.gpCount == 16'h0001)
            begin
                gpExpire = 1'b1;
                if (st.gpCfg[CFG_MODE_BIT])
                    next_st.gpCount = st.gpCfg[15:0];
            end
        end

        if (!ev.rxActive)
            next_st.wdCount = 16'h0000;
        else if (st.wdCount != st.wdCfg[15:0] && !st.wdCfg[CFG_MODE_BIT])
        begin
            next_st.wdCount = st.wdCount + 16'h0001;
            wdExpire = (st.wdCount + 16'h0001) == st.wdCfg[15:0];
        end

        setBits[BIT_GP_TIMER] = gpExpire;
        setBits[BIT_RX_WATCHDOG] = wdExpire;
        next_st.rxStopPrev = ev.rxStopped;
        setBits[BIT_RX_STOPPED] = ev.rxStopped & ~st.rxStopPrev;
        setBits[BIT_RX_DONE] = ev.rxFrameDone;
        setBits[BIT_TX_STOPPED] = ev.txStopped;

        case (st.rxState)
            DSF_RX_RUN:
            begin
                if (ev.rxNoDesc)
                begin
                    setBits[BIT_RX_NO_DESC] = 1'b1;
                    next_st.rxState = DSF_RX_SUSP;
                end
            end
            DSF_RX_SUSP:
            begin
                if (ev.rxNoDesc)
                    setBits[BIT_RX_NO_DESC] = 1'b1;
                else if ((rxPoll && ev.rxDescOwned) || ev.rxFrameArrive)
                    next_st.rxState = DSF_RX_RUN;
            end
            default: next_st.rxState = DSF_RX_RUN;
        endcase

        // transmit events, jabber first, then underflow, then descriptor
        next_st.txDescWrite = 1'b0;
        if (ev.txJabber)
        begin
            setBits[BIT_TX_JABBER] = 1'b1;
            next_st.txState = DSF_TX_HALT;
            next_st.txDescWord = RESET_ZERO;
            next_st.txDescWord[DESC_JABBER_BIT] = 1'b1;
            next_st.txDescWrite = 1'b1;
        end
        else if (ev.txUnderflow)
        begin
            setBits[BIT_TX_UNDERRUN] = 1'b1;
            next_st.txState = DSF_TX_SUSP;
            next_st.txDescWord = RESET_ZERO;
            next_st.txDescWord[DESC_UNDERRUN_BIT] = 1'b1;
            next_st.txDescWrite = 1'b1;
        end
        else if (ev.txNoDesc)
        begin
            setBits[BIT_TX_NO_DESC] = 1'b1;
            next_st.txState = DSF_TX_SUSP;
        end
        else
        begin
            case (st.txState)
                DSF_TX_RUN: next_st.txState = DSF_TX_RUN;
                DSF_TX_SUSP:
                begin
                    if (ev.txDescOwned && (st.autoPoll || txPoll))
                        next_st.txState = DSF_TX_RUN;
                end
                DSF_TX_HALT:
                begin
                    if (txPoll)
                        next_st.txState = DSF_TX_RUN;
                end
                default: next_st.txState = DSF_TX_RUN;
            endcase
        end

        next_st.flags = ((st.flags & ~clrBits) | setBits) & FLAG_MASK;
        next_st.irq = |(next_st.flags & next_st.mask);
    end

    //======================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{flags: RESET_ZERO, mask: RESET_ZERO, gpCfg: CFG_RESET,
                gpCount: 16'h0000, wdCfg: CFG_RESET, wdCount: 16'h0000,
                autoPoll: 1'b0, rxStopPrev: 1'b0, txState: DSF_TX_RUN,
                rxState: DSF_RX_RUN, txDescWord: RESET_ZERO,
                txDescWrite: 1'b0, waitReq: 1'b1, readData: RESET_ZERO,
                irq: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign avsReaddata = st.readData;
    assign avsWaitrequest = st.waitReq;
    assign irq = st.irq;
    assign txSuspend = st.txState[0];
    assign txHalt = st.txState[1];
    assign rxSuspend = st.rxState[0];
    assign txDescStatusWord = st.txDescWord;
    assign txDescStatusWrite = st.txDescWrite;

    //======================================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic clrHit6;
    assign clrHit6 = accept && avsWrite && avsAddress == ADDR_STATUS &&
        avsByteenable[0] && avsWritedata[BIT_RX_DONE];

    a_gp_timer_flag: assert property (gpExpire |=>
        st.flags[BIT_GP_TIMER]) else $error("gp timer flag not set");

    a_watchdog_flag: assert property (wdExpire |=>
        st.flags[BIT_RX_WATCHDOG]) else $error("watchdog flag missing");

    a_rx_stop_edge: assert property ($rose(ev.rxStopped) |=>
        st.flags[BIT_RX_STOPPED]) else $error("rx stop flag missing");

    a_rx_nodesc_susp: assert property (ev.rxNoDesc |=>
        rxSuspend && st.flags[BIT_RX_NO_DESC])
        else $error("rx not suspended");

    a_rx_resume: assert property (rxSuspend && ev.rxFrameArrive &&
        !ev.rxNoDesc |=> !rxSuspend) else $error("rx did not resume");

    a_rx_poll_resume: assert property (rxSuspend && rxPoll &&
        ev.rxDescOwned && !ev.rxNoDesc |=> !rxSuspend)
        else $error("rx poll resume lost");

    a_rx_done_flag: assert property (ev.rxFrameDone |=>
        st.flags[BIT_RX_DONE]) else $error("rx done flag missing");

    a_tx_underrun: assert property (ev.txUnderflow && !ev.txJabber |=>
        txSuspend && txDescStatusWrite && txDescStatusWord[DESC_UNDERRUN_BIT]
        ##1 !txDescStatusWrite) else $error("underflow wrong");

    a_tx_jabber: assert property (ev.txJabber |=> txHalt &&
        txDescStatusWord[DESC_JABBER_BIT] && st.flags[BIT_TX_JABBER])
        else $error("jabber wrong");

    a_tx_nodesc: assert property (ev.txNoDesc |=>
        st.flags[BIT_TX_NO_DESC]) else $error("tx descriptor flag missing");

    a_tx_resume: assert property (txSuspend && ev.txDescOwned &&
        (txPoll || st.autoPoll) && !ev.txJabber && !ev.txUnderflow &&
        !ev.txNoDesc |=> !txSuspend) else $error("tx did not resume");

    a_tx_hold_susp: assert property (txSuspend && !ev.txDescOwned &&
        !ev.txJabber |=> txSuspend) else $error("tx left suspend");

    a_tx_stop_level: assert property (ev.txStopped [*2] |=>
        st.flags[BIT_TX_STOPPED]) else $error("tx stop flag missing");

    a_w1c_clear: assert property (clrHit6 && !ev.rxFrameDone |=>
        !st.flags[BIT_RX_DONE]) else $error("flag not cleared");

    a_flag_latched: assert property (st.flags[BIT_GP_TIMER] &&
        !(accept && avsWrite && avsAddress == ADDR_STATUS) |=>
        st.flags[BIT_GP_TIMER]) else $error("flag dropped");

    a_set_wins: assert property (clrHit6 && ev.rxFrameDone |=>
        st.flags[BIT_RX_DONE]) else $error("set lost");

    a_reserved_zero: assert property (!st.flags[10] && !st.flags[4])
        else $error("reserved bit set");

    a_summary_read: assert property (access && st.waitReq &&
        avsAddress == ADDR_STATUS |=> avsReaddata[BIT_NORMAL_SUM] ==
        (avsReaddata[BIT_TX_NO_DESC] | avsReaddata[BIT_RX_DONE]) &&
        avsReaddata[BIT_ABNORMAL_SUM] == |(avsReaddata & ABNORMAL_MASK))
        else $error("summary bad");

    a_bus_one_wait: assert property (access && avsWaitrequest |=>
        !avsWaitrequest ##1 avsWaitrequest) else $error("bus wait bad");

    c_rx_suspend_resume: cover property (rxSuspend ##[1:20] !rxSuspend);
    c_tx_underrun: cover property (ev.txUnderflow ##1 txSuspend);
    c_set_clear_clash: cover property (clrHit6 && ev.rxFrameDone);
    c_irq_rise: cover property ($rose(irq));
endmodule // dsf_status_flags

/* File: dsf_pkg.sv */
// package: constants, types and register map of the dma status event flags
//==========================================================================
// Functional notes
// - set bit 11 when the general purpose countdown timer expires
// - set bit 9 when the receive watchdog times out
// - set bit 8 when the receive engine enters its stopped state
// - missing receive descriptor sets bit 7 and suspends reception
// - reception resumes on owned descriptor plus poll, or new frame
// - set bit 6 each time a frame reception finishes
// - transmit underflow sets bit 5, suspends, marks descriptor bit 1
// - jabber expiry sets bit 3, stops transmit, marks descriptor bit 14
// - missing transmit descriptor sets bit 2 and suspends transmission
// - transmit resumes on owned descriptor plus poll unless auto polling
// - set bit 1 whenever the transmit engine is stopped
// - flags stay latched; writing one to a bit clears it
// - bit 16 is set while bit 2 or bit 6 is set
// - bit 15 is set while any abnormal flag is set
package dsf_pkg;
    //======================================================================
    // register map (word addresses, word index in avs address)
    localparam logic [2:0] ADDR_STATUS = 3'h0;
    localparam logic [2:0] ADDR_MASK = 3'h1;
    localparam logic [2:0] ADDR_GP_TIMER = 3'h2;
    localparam logic [2:0] ADDR_WATCHDOG = 3'h3;
    localparam logic [2:0] ADDR_POLL = 3'h4;
    //======================================================================
    // status field positions
    localparam int BIT_TX_STOPPED = 1;
    localparam int BIT_TX_NO_DESC = 2;
    localparam int BIT_TX_JABBER = 3;
    localparam int BIT_TX_UNDERRUN = 5;
    localparam int BIT_RX_DONE = 6;
    localparam int BIT_RX_NO_DESC = 7;
    localparam int BIT_RX_STOPPED = 8;
    localparam int BIT_RX_WATCHDOG = 9;
    localparam int BIT_GP_TIMER = 11;
    localparam int BIT_ABNORMAL_SUM = 15;
    localparam int BIT_NORMAL_SUM = 16;
    localparam logic [31:0] FLAG_MASK = 32'h0000_0bee;
    localparam logic [31:0] NORMAL_MASK = 32'h0000_0044;
    localparam logic [31:0] ABNORMAL_MASK = 32'h0000_0baa;
    //======================================================================
    // descriptor status word bits, poll register bits, timer config
    localparam int DESC_UNDERRUN_BIT = 1;
    localparam int DESC_JABBER_BIT = 14;
    localparam int POLL_TX_BIT = 0;
    localparam int POLL_RX_BIT = 1;
    localparam int POLL_AUTO_BIT = 2;
    localparam int POLL_TX_SUSP_BIT = 3;
    localparam int POLL_RX_SUSP_BIT = 4;
    localparam int CFG_MODE_BIT = 16;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam logic [16:0] CFG_RESET = 17'h0_0000;
    //======================================================================
    // engine states
    typedef enum logic [1:0] {
        DSF_TX_RUN = 2'b00,
        DSF_TX_SUSP = 2'b01,
        DSF_TX_HALT = 2'b10
    } dsf_tx_state_t;
    typedef enum logic [0:0] {
        DSF_RX_RUN = 1'b0,
        DSF_RX_SUSP = 1'b1
    } dsf_rx_state_t;
    //======================================================================
    // event inputs from the dma engines, all on clk
    typedef struct packed {
        logic txStopped;
        logic txNoDesc;
        logic txJabber;
        logic txUnderflow;
        logic txDescOwned;
        logic rxStopped;
        logic rxNoDesc;
        logic rxFrameDone;
        logic rxFrameArrive;
        logic rxDescOwned;
        logic rxActive;
    } dsf_events_t;
    //======================================================================
    // complete block state
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] mask;
        logic [16:0] gpCfg;
        logic [15:0] gpCount;
        logic [16:0] wdCfg;
        logic [15:0] wdCount;
        logic autoPoll;
        logic rxStopPrev;
        dsf_tx_state_t txState;
        dsf_rx_state_t rxState;
        logic [31:0] txDescWord;
        logic txDescWrite;
        logic waitReq;
        logic [31:0] readData;
        logic irq;
    } dsf_state_t;
endpackage

/* File: dsf_status_flags_bench.sv */
// self-checking testbench for the dma status event flags block
`timescale 1ns/10ps
module dsf_status_flags_bench
    import dsf_pkg::*;
;
    //======================================================================
    // signals
    logic clk;
    logic rst_n;
    logic [2:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWritedata;
    logic [3:0] avsByteenable;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    dsf_events_t ev;
    logic irq;
    logic txSuspend;
    logic txHalt;
    logic rxSuspend;
    logic [31:0] txDescStatusWord;
    logic txDescStatusWrite;
    int errors;
    int numChecks;
    logic [31:0] rd;
    dsf_events_t pNone;

    dsf_status_flags u_dsf_status_flags (
        .clk(clk),
        .rst_n(rst_n),
        .avsAddress(avsAddress),
        .avsRead(avsRead),
        .avsWrite(avsWrite),
        .avsWritedata(avsWritedata),
        .avsByteenable(avsByteenable),
        .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest),
        .ev(ev),
        .irq(irq),
        .txSuspend(txSuspend),
        .txHalt(txHalt),
        .rxSuspend(rxSuspend),
        .txDescStatusWord(txDescStatusWord),
        .txDescStatusWrite(txDescStatusWrite)
    );

    always #12.5 clk = ~clk;

    //======================================================================
    // compare, bus and event tasks
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        numChecks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsRead <= 1'b1;
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        d = avsReaddata;
        avsRead <= 1'b0;
    endtask

    task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        avsAddress <= a;
        avsWritedata <= d;
        avsByteenable <= 4'hf;
        avsWrite <= 1'b1;
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        avsWrite <= 1'b0;
    endtask

    task automatic pulse(input dsf_events_t p);
        @(posedge clk);
        ev <= ev | p;
        @(posedge clk);
        ev <= ev & ~p;
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        ev <= pNone;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    //======================================================================
    // scenarios
    task automatic t_regs;
        chk1(avsWaitrequest, 1'b1);
        for (int a = 0; a < 8; a++)
        begin
            bus_rd(3'(a), rd);
            chk32(rd, 32'h0000_0000);
        end
        bus_wr(3'h5, 32'hffff_ffff);
        bus_rd(3'h5, rd);
        chk32(rd, 32'h0000_0000);
        chk1(irq | txSuspend | rxSuspend | txHalt, 1'b0);
    endtask

    task automatic t_flags;
        int evIdx[5] = '{4, 3, 9, 7, 8};
        int fb[5] = '{7, 6, 2, 5, 3};
        logic [31:0] exp;
        for (int i = 0; i < 5; i++)
        begin
            pulse(dsf_events_t'(11'h001 << evIdx[i]));
            exp = 32'h1 << fb[i];
            exp[16] = NORMAL_MASK[fb[i]];
            exp[15] = ABNORMAL_MASK[fb[i]];
            bus_rd(ADDR_STATUS, rd);
            chk32(rd, exp);
            chk1(irq, 1'b0);
            bus_wr(ADDR_STATUS, ~(32'h1 << fb[i]));
            bus_rd(ADDR_STATUS, rd);
            chk32(rd, exp);
            bus_wr(ADDR_STATUS, 32'h1 << fb[i]);
            bus_rd(ADDR_STATUS, rd);
            chk32(rd, 32'h0000_0000);
        end
    endtask

    task automatic t_stopped;
        @(posedge clk);
        ev.rxStopped <= 1'b1;
        ev.txStopped <= 1'b1;
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_8102);
        bus_wr(ADDR_STATUS, 32'h0000_0102);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_8002);
        @(posedge clk);
        ev.rxStopped <= 1'b0;
        ev.txStopped <= 1'b0;
        bus_wr(ADDR_STATUS, 32'h0000_0002);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_0000);
    endtask

    task automatic t_irq;
        dsf_events_t p;
        bus_wr(ADDR_MASK, 32'hffff_ffff);
        bus_rd(ADDR_MASK, rd);
        chk32(rd, FLAG_MASK);
        bus_wr(ADDR_MASK, 32'h0000_0040);
        p = pNone;
        p.txNoDesc = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(irq, 1'b0);
        p = pNone;
        p.rxFrameDone = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(irq, 1'b1);
        @(posedge clk);
        avsAddress <= ADDR_STATUS;
        avsWritedata <= 32'h0000_0040;
        avsWrite <= 1'b1;
        ev.rxFrameDone <= 1'b1;
        do
            @(posedge clk);
        while (avsWaitrequest !== 1'b0);
        ev.rxFrameDone <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge clk);
        chk1(irq, 1'b1);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0001_0044);
        bus_wr(ADDR_STATUS, 32'h0000_0044);
        @(posedge clk);
        chk1(irq, 1'b0);
    endtask

    task automatic t_tx_engine;
        dsf_events_t p;
        p = pNone;
        p.txNoDesc = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(txSuspend, 1'b1);
        ev.txDescOwned <= 1'b1;
        repeat (4) @(posedge clk);
        chk1(txSuspend, 1'b1);
        bus_wr(ADDR_POLL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk1(txSuspend, 1'b0);
        bus_wr(ADDR_POLL, 32'h0000_0004);
        pulse(p);
        @(posedge clk);
        chk1(txSuspend, 1'b1);
        repeat (2) @(posedge clk);
        chk1(txSuspend, 1'b0);
        ev.txDescOwned <= 1'b0;
        bus_wr(ADDR_POLL, 32'h0000_0000);
        p = pNone;
        p.txUnderflow = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(txDescStatusWrite & txSuspend, 1'b1);
        chk32(txDescStatusWord, 32'h0000_0002);
        p = pNone;
        p.txJabber = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(txDescStatusWrite & txHalt, 1'b1);
        chk32(txDescStatusWord, 32'h0000_4000);
        bus_wr(ADDR_POLL, 32'h0000_0001);
        @(posedge clk);
        chk1(txHalt, 1'b0);
    endtask

    task automatic t_rx_engine;
        dsf_events_t p;
        p = pNone;
        p.rxNoDesc = 1'b1;
        pulse(p);
        @(posedge clk);
        chk1(rxSuspend, 1'b1);
        bus_wr(ADDR_POLL, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk1(rxSuspend, 1'b1);
        ev.rxDescOwned <= 1'b1;
        bus_wr(ADDR_POLL, 32'h0000_0002);
        repeat (2) @(posedge clk);
        chk1(rxSuspend, 1'b0);
        ev.rxDescOwned <= 1'b0;
        pulse(p);
        @(posedge clk);
        chk1(rxSuspend, 1'b1);
        p = pNone;
        p.rxFrameArrive = 1'b1;
        pulse(p);
        repeat (2) @(posedge clk);
        chk1(rxSuspend, 1'b0);
    endtask

    task automatic t_timers;
        bus_wr(ADDR_GP_TIMER, 32'd20);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_0000);
        repeat (20) @(posedge clk);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_8800);
        bus_wr(ADDR_WATCHDOG, 32'd8);
        @(posedge clk);
        ev.rxActive <= 1'b1;
        repeat (2) @(posedge clk);
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_8800);
        repeat (10) @(posedge clk);
        ev.rxActive <= 1'b0;
        bus_rd(ADDR_STATUS, rd);
        chk32(rd, 32'h0000_8a00);
    endtask

    //======================================================================
    // verdict and main sequence
    task automatic close_out;
        $display("checks %0d errors %0d", numChecks, errors);
        if (errors == 0 && numChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        avsAddress = 3'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0000_0000;
        avsByteenable = 4'hf;
        pNone = '0;
        ev = pNone;
        errors = 0;
        numChecks = 0;
        do_reset();
        t_regs();
        t_flags();
        do_reset();
        t_stopped();
        t_irq();
        do_reset();
        t_tx_engine();
        do_reset();
        t_rx_engine();
        do_reset();
        t_timers();
        close_out();
    end
endmodule // dsf_status_flags_bench
